// ===== logic/mrip_pkg.sv
// shared constants and carriers of the recall / interlock port
package mrip_pkg;

  // register byte offsets on the wishbone bus
  localparam logic [7:0] OFS_CTRL     = 8'h00; // control bits
  localparam logic [7:0] OFS_STATUS   = 8'h04; // live state, read only
  localparam logic [7:0] OFS_ACTIVE   = 8'h08; // active setting, read only
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0C; // sticky events, read only
  localparam logic [7:0] OFS_IRQ_CLR  = 8'h10; // write one to clear
  localparam logic [7:0] OFS_IRQ_EN   = 8'h14; // interrupt enables

  // control register fields and reset value
  localparam int unsigned CTRL_RECALL_EN_BIT = 0; // accept recalls
  localparam int unsigned CTRL_START_EN_BIT  = 1; // accept starts
  localparam int unsigned CTRL_SW_START_BIT  = 2; // self clearing start
  localparam int unsigned CTRL_SW_STOP_BIT   = 3; // self clearing stop
  localparam logic [1:0]  CTRL_RESET         = 2'h3;

  // status register fields
  localparam int unsigned ST_READY_BIT   = 0;
  localparam int unsigned ST_TEST_BIT    = 1;
  localparam int unsigned ST_PROT_BIT    = 2;
  localparam int unsigned ST_ILK_BIT     = 3;
  localparam int unsigned ST_ILK_LAT_BIT = 4;

  // interrupt event fields
  localparam int unsigned IRQ_W            = 4;
  localparam int unsigned IRQ_RECALL_BIT   = 0; // recall carried out
  localparam int unsigned IRQ_REJECT_BIT   = 1; // recall refused
  localparam int unsigned IRQ_ILK_BIT      = 2; // interlock opened
  localparam int unsigned IRQ_PCLR_BIT     = 3; // protection cleared
  localparam logic [3:0]  IRQ_EN_RESET     = 4'h0;

  // recall categories, {bit1, bit0} of the category select pins
  localparam logic [1:0] CAT_ACW  = 2'h3; // ac withstand settings
  localparam logic [1:0] CAT_DCW  = 2'h2; // dc withstand settings
  localparam logic [1:0] CAT_IR   = 2'h1; // insulation resistance
  localparam logic [1:0] CAT_AUTO = 2'h0; // stored test programs

  // bcd limits and pin synchroniser
  localparam logic [3:0] BCD_MAX     = 4'h9;
  localparam logic [6:0] ENTRY_SCALE = 7'h0A; // tens digit weight
  localparam int unsigned PIN_W      = 12;
  localparam logic [11:0] PIN_IDLE   = 12'hFFF; // pulled-up level

  // test sequencing states
  typedef enum logic [2:0] {
    ST_READY = 3'b001,
    ST_TEST  = 3'b010,
    ST_PROT  = 3'b100
  } mrip_state_e;

  // connector pins as seen after synchronisation
  typedef struct packed {
    logic       strobe_n;
    logic [7:0] number_n;
    logic [1:0] category;
    logic       interlock_open;
  } mrip_pins_s;

  // one accepted recall
  typedef struct packed {
    logic [1:0] category;
    logic [6:0] entry;
  } mrip_recall_s;

endpackage

// ===== logic/mrip_port.sv
// Functional notes
// - two select bits choose recall category
// - eight inputs are two active-low bcd digits
// - entries 0 to 99 load as active
// - open inputs read high, inactive
// - dc category refused on non-dc variant
// - open interlock protects, cuts output, disables testing
// - protected state ignores every start source
// - stop cannot clear while interlock open
// - close interlock first, then stop clears
// - comes up protected with interlock latched
// - open contact drives interlock signal high
// - ready output asserted during ready state
// - protection output asserted while protected
`timescale 1ns/1ns
`default_nettype none
module mrip_port #(
  parameter bit DC_CAPABLE = 1'b1 // variant with dc withstand
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // connector pins, asynchronous
  input  wire logic        category_select_bit0_i,
  input  wire logic        category_select_bit1_i,
  input  wire logic [7:0]  recall_number_select_n_i,
  input  wire logic        recall_strobe_n_i,
  input  wire logic        interlock_open_i,
  // start and stop requests from internal decoders
  input  wire logic [3:0]  start_req_i,
  input  wire logic [3:0]  stop_req_i,
  input  wire logic        test_done_i,
  // connector and tester outputs
  output logic             ready_n_o,
  output logic             protection_o,
  output logic             test_output_en_o,
  output logic             recall_load_o,
  output logic      [1:0]  recall_category_o,
  output logic      [6:0]  recall_entry_o,
  output logic             irq_o
);

  // raw pin vector and its synchronised copy
  mrip_pkg::mrip_pins_s          pins_raw;   // straight from pads
  logic [mrip_pkg::PIN_W-1:0]   sync_w;     // after two flops
  mrip_pkg::mrip_pins_s          pins;       // typed view of sync_w

  assign pins_raw = {recall_strobe_n_i, recall_number_select_n_i,
                     category_select_bit1_i, category_select_bit0_i,
                     interlock_open_i};
  assign pins     = mrip_pkg::mrip_pins_s'(sync_w);

  // two flop synchroniser per pin, idle level high like the pull-ups
  genvar g;
  for (g = 0; g < mrip_pkg::PIN_W; g++) begin : g_sync
    logic meta_q;   // first stage, read only by the second
    logic stable_q; // second stage
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        meta_q   <= mrip_pkg::PIN_IDLE[g];
        stable_q <= mrip_pkg::PIN_IDLE[g];
      end else begin
        meta_q   <= pins_raw[g];
        stable_q <= meta_q;
      end
    end
    assign sync_w[g] = stable_q;
  end

  // control and state registers
  logic                       recall_en_q;  // software recall gate
  logic                       start_en_q;   // software start gate
  logic                       sw_start_q;   // one cycle command start
  logic                       sw_stop_q;    // one cycle command stop
  mrip_pkg::mrip_state_e      state_q;      // sequencing state
  mrip_pkg::mrip_state_e      state_d;
  logic                       ilk_lat_q;    // protection came from interlock
  logic                       ilk_prev_q;   // interlock one cycle ago
  logic                       strobe_prev_q;// strobe one cycle ago
  mrip_pkg::mrip_recall_s     active_q;     // active setting
  logic [mrip_pkg::IRQ_W-1:0] irq_stat_q;   // sticky events
  logic [mrip_pkg::IRQ_W-1:0] irq_en_q;     // event enables
  logic                       ack_q;        // bus acknowledge

  // recall decode
  logic       strobe_fall; // active edge of the strobe
  logic [3:0] tens_w;      // tens digit, active high
  logic [3:0] units_w;     // units digit, active high
  logic [6:0] entry_w;     // binary entry number
  logic       digits_ok;   // both digits are valid bcd
  logic       dc_bad;      // dc asked on a non-dc variant
  logic       accept_w;    // recall carried out this cycle
  logic       reject_w;    // strobe seen but refused
  logic       ilk_open;    // interlock contact open
  logic       start_any;   // start from any source
  logic       stop_any;    // stop from any source

  assign ilk_open    = pins.interlock_open;
  assign strobe_fall = strobe_prev_q & ~pins.strobe_n;
  assign tens_w      = ~pins.number_n[7:4];
  assign units_w     = ~pins.number_n[3:0];
  assign entry_w     = 7'({3'h0, tens_w} * mrip_pkg::ENTRY_SCALE)
                       + {3'h0, units_w};
  assign digits_ok   = (tens_w <= mrip_pkg::BCD_MAX) &&
                       (units_w <= mrip_pkg::BCD_MAX);
  assign dc_bad      = !DC_CAPABLE &&
                       (pins.category == mrip_pkg::CAT_DCW);
  // recalls only land while ready; others are refused and flagged
  assign accept_w    = strobe_fall && recall_en_q && digits_ok &&
                       !dc_bad && (state_q == mrip_pkg::ST_READY);
  assign reject_w    = strobe_fall && !accept_w;
  assign start_any   = ((|start_req_i) || sw_start_q) && start_en_q;
  assign stop_any    = (|stop_req_i) || sw_stop_q;

  // edge detect history for strobe and interlock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strobe_prev_q <= 1'b1;
      ilk_prev_q    <= 1'b1;
    end else begin
      strobe_prev_q <= pins.strobe_n;
      ilk_prev_q    <= ilk_open;
    end
  end

  // recall execution: load the chosen entry as the active one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      recall_load_o     <= 1'b0;
      recall_category_o <= mrip_pkg::CAT_ACW;
      recall_entry_o    <= 7'h00;
      active_q          <= '0;
    end else begin
      recall_load_o <= accept_w;
      if (accept_w) begin
        recall_category_o <= pins.category;
        recall_entry_o    <= entry_w;
        active_q          <= {pins.category, entry_w};
      end
    end
  end

  // next state of test sequencing
  always_comb begin
    state_d = state_q;
    case (state_q)
      mrip_pkg::ST_READY: begin
        if (start_any) begin
          state_d = mrip_pkg::ST_TEST;
        end
      end
      mrip_pkg::ST_TEST: begin
        if (stop_any || test_done_i) begin
          state_d = mrip_pkg::ST_READY;
        end
      end
      mrip_pkg::ST_PROT: begin
        // starts ignored; stop clears only with the contact closed
        if (stop_any && !ilk_open) begin
          state_d = mrip_pkg::ST_READY;
        end
      end
      default: begin
        state_d = mrip_pkg::ST_PROT;
      end
    endcase
    // an open interlock overrides everything, stop included
    if (ilk_open) begin
      state_d = mrip_pkg::ST_PROT;
    end
  end

  // state and connector outputs, registered from the next state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q          <= mrip_pkg::ST_PROT;
      ilk_lat_q        <= 1'b1;
      ready_n_o        <= 1'b1;
      protection_o     <= 1'b1;
      test_output_en_o <= 1'b0;
    end else begin
      state_q          <= state_d;
      ready_n_o        <= (state_d != mrip_pkg::ST_READY);
      protection_o     <= (state_d == mrip_pkg::ST_PROT);
      test_output_en_o <= (state_d == mrip_pkg::ST_TEST);
      if (ilk_open) begin
        ilk_lat_q <= 1'b1;
      end else if (state_d != mrip_pkg::ST_PROT) begin
        ilk_lat_q <= 1'b0;
      end
    end
  end

  // bus decode
  logic        req_w;   // live request
  logic        wr_fire; // write lands at the acknowledged edge
  logic [31:0] rd_data; // read mux

  assign req_w   = wb_cyc_i && wb_stb_i;
  assign wr_fire = req_w && wb_we_i && ack_q && wb_sel_i[0];

  // acknowledge one cycle after the request, then drop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q    <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      ack_q    <= req_w && !ack_q;
      wb_ack_o <= req_w && !ack_q;
      if (req_w && !ack_q) begin
        wb_dat_o <= rd_data;
      end
    end
  end

  // read mux; unmapped and write-only offsets read zero
  always_comb begin
    rd_data = 32'h0000_0000;
    case (wb_adr_i)
      mrip_pkg::OFS_CTRL: begin
        rd_data[mrip_pkg::CTRL_RECALL_EN_BIT] = recall_en_q;
        rd_data[mrip_pkg::CTRL_START_EN_BIT]  = start_en_q;
      end
      mrip_pkg::OFS_STATUS: begin
        rd_data[mrip_pkg::ST_READY_BIT]   = state_q == mrip_pkg::ST_READY;
        rd_data[mrip_pkg::ST_TEST_BIT]    = state_q == mrip_pkg::ST_TEST;
        rd_data[mrip_pkg::ST_PROT_BIT]    = state_q == mrip_pkg::ST_PROT;
        rd_data[mrip_pkg::ST_ILK_BIT]     = ilk_open;
        rd_data[mrip_pkg::ST_ILK_LAT_BIT] = ilk_lat_q;
      end
      mrip_pkg::OFS_ACTIVE: begin
        rd_data[8:0] = active_q;
      end
      mrip_pkg::OFS_IRQ_STAT: begin
        rd_data[mrip_pkg::IRQ_W-1:0] = irq_stat_q;
      end
      mrip_pkg::OFS_IRQ_EN: begin
        rd_data[mrip_pkg::IRQ_W-1:0] = irq_en_q;
      end
      default: begin
        rd_data = 32'h0000_0000;
      end
    endcase
  end

  // control register, command bits clear themselves
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      recall_en_q <= mrip_pkg::CTRL_RESET[mrip_pkg::CTRL_RECALL_EN_BIT];
      start_en_q  <= mrip_pkg::CTRL_RESET[mrip_pkg::CTRL_START_EN_BIT];
      sw_start_q  <= 1'b0;
      sw_stop_q   <= 1'b0;
    end else begin
      sw_start_q <= 1'b0;
      sw_stop_q  <= 1'b0;
      if (wr_fire && wb_adr_i == mrip_pkg::OFS_CTRL) begin
        recall_en_q <= wb_dat_i[mrip_pkg::CTRL_RECALL_EN_BIT];
        start_en_q  <= wb_dat_i[mrip_pkg::CTRL_START_EN_BIT];
        sw_start_q  <= wb_dat_i[mrip_pkg::CTRL_SW_START_BIT];
        sw_stop_q   <= wb_dat_i[mrip_pkg::CTRL_SW_STOP_BIT];
      end
    end
  end

  // interrupt events; a new event wins over a clear in the same cycle
  logic [mrip_pkg::IRQ_W-1:0] ev_w;  // events this cycle
  logic [mrip_pkg::IRQ_W-1:0] clr_w; // clear mask this cycle

  assign ev_w  = {(state_q == mrip_pkg::ST_PROT) &&
                  (state_d == mrip_pkg::ST_READY),
                  ilk_open && !ilk_prev_q, reject_w, accept_w};
  assign clr_w = (wr_fire && wb_adr_i == mrip_pkg::OFS_IRQ_CLR) ?
                 wb_dat_i[mrip_pkg::IRQ_W-1:0] : '0;

  // sticky status, enables and the level interrupt
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_q <= '0;
      irq_en_q   <= mrip_pkg::IRQ_EN_RESET;
      irq_o      <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~clr_w) | ev_w;
      irq_o      <= |(((irq_stat_q & ~clr_w) | ev_w) & irq_en_q);
      if (wr_fire && wb_adr_i == mrip_pkg::OFS_IRQ_EN) begin
        irq_en_q <= wb_dat_i[mrip_pkg::IRQ_W-1:0];
      end
    end
  end

  // checks on the recall and interlock behaviour
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_CATEGORY: assert property (
    accept_w |=> recall_load_o &&
                 recall_category_o == $past(pins.category))
    else $error("recall category not taken from select bits");

  AST_BCD_ENTRY: assert property (
    accept_w |=> recall_entry_o ==
      7'({3'h0, ~$past(pins.number_n[7:4])} * 7'h0A) +
      {3'h0, ~$past(pins.number_n[3:0])})
    else $error("entry not decoded from inverted bcd digits");

  AST_ENTRY_ACTIVE: assert property (
    recall_load_o |-> recall_entry_o <= 7'h63 &&
                      active_q == {recall_category_o, recall_entry_o})
    else $error("recalled entry not made active or out of range");

  AST_DC_REFUSED: assert property (
    strobe_fall && dc_bad |=> !recall_load_o && irq_stat_q[1])
    else $error("dc recall acted on by non-dc variant");

  AST_OPEN_PROTECTS: assert property (
    ilk_open |=> protection_o && !test_output_en_o && ready_n_o)
    else $error("open interlock did not protect and cut output");

  AST_NO_START: assert property (
    state_q == mrip_pkg::ST_PROT && start_any && !stop_any
      |=> state_q == mrip_pkg::ST_PROT && !test_output_en_o)
    else $error("start accepted while protected");

  AST_STOP_HELD: assert property (
    ilk_open && stop_any |=> protection_o)
    else $error("stop cleared protection with interlock open");

  AST_RECOVER: assert property (
    state_q == mrip_pkg::ST_PROT && !ilk_open && stop_any
      |=> !protection_o && !ready_n_o)
    else $error("stop with interlock closed did not clear");

  AST_POWER_UP: assert property (
    $fell(rst_i) |-> protection_o && ilk_lat_q && !test_output_en_o)
    else $error("not protected after reset");

  AST_PIN_TRIGGER: assert property (
    interlock_open_i [*3] |=> protection_o)
    else $error("interlock pin high did not trigger protection");

  AST_READY_OUT: assert property (
    !ready_n_o |-> !protection_o && !test_output_en_o)
    else $error("ready shown outside ready state");

  AST_PROT_OUT: assert property (
    protection_o == (state_q == mrip_pkg::ST_PROT))
    else $error("protection output disagrees with state");

  AST_STROBE_EDGE: assert property (
    recall_load_o |-> $past(strobe_fall) && !$past(pins.strobe_n))
    else $error("recall without strobe falling edge");

  COV_RECALL: cover property (accept_w ##1 recall_load_o);
  COV_REJECT: cover property (reject_w);
  COV_RECOVER: cover property (
    state_q == mrip_pkg::ST_PROT && !ilk_open && stop_any ##1 !protection_o);
  COV_TEST: cover property (start_any ##1 test_output_en_o);

endmodule
`default_nettype wire

// ===== test/mrip_ctrl_model.sv
`timescale 1ns/1ns
`default_nettype none
// far-side controller: select pins, strobe and interlock contact
module mrip_ctrl_model (
  // clock and ready feedback
  input  wire logic       clk_i,
  input  wire logic       ready_n_i,
  // connector pins towards the port
  output logic            cat0_o,
  output logic            cat1_o,
  output logic [7:0]      num_n_o,
  output logic            strobe_n_o,
  output logic            ilk_open_o
);
  // all contacts open at power-up, so every pin rests high
  initial begin
    {cat1_o, cat0_o, num_n_o, strobe_n_o, ilk_open_o} = 12'hFFF;
  end

  // one recall; ign_rdy strobes even when the port is not ready
  task automatic recall(input logic [1:0] cat, input logic [3:0] tens,
                        input logic [3:0] units, input bit ign_rdy);
    @(posedge clk_i);
    {cat1_o, cat0_o} <= cat;
    num_n_o <= ~{tens, units};
    // selects settle well before the strobe edge
    repeat (4) @(posedge clk_i);
    if (!ready_n_i || ign_rdy) begin
      strobe_n_o <= 1'b0;
      repeat (6) @(posedge clk_i);
      strobe_n_o <= 1'b1;
    end
    repeat (4) @(posedge clk_i);
    // released contacts go back to the pulled-up level
    {cat1_o, cat0_o, num_n_o} <= 10'h3FF;
    @(posedge clk_i);
  endtask

  // open or close the interlock contact, then let it settle
  task automatic interlock(input logic open);
    @(posedge clk_i);
    ilk_open_o <= open;
    repeat (5) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// ===== test/memory_recall_interlock_port_test.sv
`timescale 1ns/1ns
`default_nettype none
// compare and count, report a mismatch at once
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin error_cnt++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, e); end end
module memory_recall_interlock_port_test;
  // clock, reset and bus
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we  = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wd  = 32'h0000_0000;
  logic [31:0] rdat;
  logic        ack;
  // pins and tester requests
  logic        c0, c1, stb_n, ilk;
  logic [7:0]  num_n;
  logic [3:0]  start = 4'h0;
  logic [3:0]  stop  = 4'h0;
  logic        done  = 1'b0;
  // outputs
  logic        rdy_n, prot, out_en, ld, ld2, irq;
  logic [1:0]  rcat;
  logic [6:0]  rent;
  // bookkeeping
  int          error_cnt = 0;
  int          cmp_count = 0;
  bit          seen, seen2;
  logic [31:0] r;

  always #2 clk = ~clk;

  mrip_ctrl_model u_ctrl (.clk_i(clk), .ready_n_i(rdy_n), .cat0_o(c0),
    .cat1_o(c1), .num_n_o(num_n), .strobe_n_o(stb_n), .ilk_open_o(ilk));

  mrip_port DUT (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd),
    .wb_dat_o(rdat), .wb_ack_o(ack), .category_select_bit0_i(c0),
    .category_select_bit1_i(c1), .recall_number_select_n_i(num_n),
    .recall_strobe_n_i(stb_n), .interlock_open_i(ilk), .start_req_i(start),
    .stop_req_i(stop), .test_done_i(done), .ready_n_o(rdy_n),
    .protection_o(prot), .test_output_en_o(out_en), .recall_load_o(ld),
    .recall_category_o(rcat), .recall_entry_o(rent), .irq_o(irq));

  // variant without dc withstand, sharing every input
  mrip_port #(.DC_CAPABLE(1'b0)) DUT_NODC (.clk_i(clk), .rst_i(rst),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(), .wb_ack_o(),
    .category_select_bit0_i(c0), .category_select_bit1_i(c1),
    .recall_number_select_n_i(num_n), .recall_strobe_n_i(stb_n),
    .interlock_open_i(ilk), .start_req_i(start), .stop_req_i(stop),
    .test_done_i(done), .ready_n_o(), .protection_o(), .test_output_en_o(),
    .recall_load_o(ld2), .recall_category_o(), .recall_entry_o(), .irq_o());

  // remember any load pulse of either instance
  always @(posedge clk) begin
    if (ld === 1'b1) seen = 1'b1;
    if (ld2 === 1'b1) seen2 = 1'b1;
  end

  // verdict and end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // classic single wishbone cycle, waits for ack under a bound
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {cyc, stb, we, adr, wd} <= {2'b11, w, a, d};
    @(posedge clk);
    while (ack !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    r = rdat;
    if (n == 20) begin
      error_cnt++;
      summarize();
    end
    {cyc, stb} <= 2'b00;
    @(posedge clk);
  endtask

  // one-cycle pulse on a request vector, then let outputs land
  task automatic pulse(input bit is_stop, input logic [3:0] v);
    @(posedge clk);
    if (is_stop) stop <= v;
    else start <= v;
    @(posedge clk);
    {start, stop} <= 8'h00;
    repeat (2) @(posedge clk);
    #1;
  endtask

  // power-up state and register reset values
  task automatic t_reset();
    `CHK({rdy_n, prot, out_en, irq}, 4'b1100)
    wb(1'b0, mrip_pkg::OFS_STATUS, 32'h0000_0000);
    `CHK(r[4:0], 5'h1C)
    wb(1'b0, mrip_pkg::OFS_CTRL, 32'h0000_0000);
    `CHK(r[1:0], mrip_pkg::CTRL_RESET)
    wb(1'b0, mrip_pkg::OFS_IRQ_EN, 32'h0000_0000);
    `CHK(r[3:0], mrip_pkg::IRQ_EN_RESET)
    wb(1'b0, 8'h3C, 32'h0000_0000);
    `CHK(r, 32'h0000_0000)
    $display("test reset done");
  endtask

  // starts and stops refused while open, recovery after closing
  task automatic t_protect();
    pulse(1'b0, 4'hF);
    `CHK({rdy_n, prot, out_en}, 3'b110)
    seen = 1'b0;
    u_ctrl.recall(mrip_pkg::CAT_ACW, 4'h0, 4'h1, 1'b1);
    `CHK(seen, 1'b0)
    pulse(1'b1, 4'hF);
    `CHK({rdy_n, prot}, 2'b11)
    u_ctrl.interlock(1'b0);
    `CHK(prot, 1'b1)
    pulse(1'b1, 4'h8);
    `CHK({rdy_n, prot}, 2'b00)
    $display("test protect done");
  endtask

  // every category at boundary entries, active register and irq
  task automatic t_recall();
    logic [6:0] e;
    logic [6:0] tab [5];
    tab = '{7'h00, 7'h01, 7'h02, 7'h62, 7'h63};
    wb(1'b1, mrip_pkg::OFS_IRQ_EN, 32'h0000_0001);
    for (int c = 0; c < 4; c++) begin
      for (int j = 0; j < 5; j++) begin
        e = tab[j];
        seen = 1'b0;
        seen2 = 1'b0;
        u_ctrl.recall(2'(c), 4'(e / 7'h0A), 4'(e % 7'h0A), 1'b0);
        `CHK({seen, rcat, rent}, {1'b1, 2'(c), e})
        `CHK(seen2, 1'(c != 2))
      end
    end
    wb(1'b0, mrip_pkg::OFS_ACTIVE, 32'h0000_0000);
    `CHK(r[8:0], {2'h3, 7'h63})
    `CHK(irq, 1'b1)
    wb(1'b1, mrip_pkg::OFS_IRQ_EN, 32'h0000_0000);
    #1;
    `CHK(irq, 1'b0)
    wb(1'b1, mrip_pkg::OFS_IRQ_EN, 32'h0000_0001);
    #1;
    `CHK(irq, 1'b1)
    wb(1'b1, mrip_pkg::OFS_IRQ_CLR, 32'h0000_000F);
    #1;
    `CHK(irq, 1'b0)
    $display("test recall done");
  endtask

  // a tens digit above nine is refused
  task automatic t_badbcd();
    seen = 1'b0;
    u_ctrl.recall(mrip_pkg::CAT_IR, 4'hA, 4'h0, 1'b0);
    `CHK(seen, 1'b0)
    wb(1'b0, mrip_pkg::OFS_IRQ_STAT, 32'h0000_0000);
    `CHK(r[1:0], 2'h2)
    wb(1'b1, mrip_pkg::OFS_IRQ_CLR, 32'h0000_000F);
    $display("test badbcd done");
  endtask

  // run, finish, run again and open the interlock mid-test
  task automatic t_run();
    pulse(1'b0, 4'h4);
    `CHK({rdy_n, out_en}, 2'b11)
    @(posedge clk);
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    `CHK({rdy_n, out_en}, 2'b00)
    // start gate closed: every start source is ignored
    wb(1'b1, mrip_pkg::OFS_CTRL, 32'h0000_0001);
    pulse(1'b0, 4'hF);
    `CHK({rdy_n, out_en}, 2'b00)
    // command start and stop, recalls gated off
    wb(1'b1, mrip_pkg::OFS_CTRL, 32'h0000_0006);
    #1;
    `CHK({rdy_n, out_en}, 2'b11)
    wb(1'b1, mrip_pkg::OFS_CTRL, 32'h0000_000A);
    #1;
    `CHK({rdy_n, out_en}, 2'b00)
    seen = 1'b0;
    u_ctrl.recall(mrip_pkg::CAT_ACW, 4'h1, 4'h2, 1'b0);
    `CHK(seen, 1'b0)
    wb(1'b1, mrip_pkg::OFS_CTRL, 32'h0000_0003);
    pulse(1'b0, 4'h1);
    u_ctrl.interlock(1'b1);
    `CHK({prot, out_en}, 2'b10)
    wb(1'b0, mrip_pkg::OFS_IRQ_STAT, 32'h0000_0000);
    `CHK(r[2], 1'b1)
    $display("test run done");
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    t_reset();
    t_protect();
    t_recall();
    t_badbcd();
    t_run();
    summarize();
  end
endmodule
`default_nettype wire
